/* design/monitor_res_regs.svh */
/*
  Constants of the monitoring resource server: resource identifiers,
  address field positions, defining values, fault codes and timing.
  Assumes inclusion by the design file only.
*/
`ifndef MONITOR_RES_REGS_SVH
`define MONITOR_RES_REGS_SVH

// ==========================================================
// Resource identifiers and address fields
`define RID_MAX_SPEED      10'h0c6
`define RID_CUR_SPEED      10'h0c7
`define RID_ACCEL_LIMIT    10'h0c8
`define RID_LIFETIME       10'h0cb
`define RID_FAULT_LOG      10'h0cc
`define ADDR_OFFSET_BIT    13
`define ADDR_DATA_BIT      12
`define ADDR_LEN_HI        11
`define ADDR_LEN_LO        10

// ==========================================================
// Defining value indices and values
`define DEF_NAME           8'h00
`define DEF_SIZE           8'h01
`define DEF_READ_LEVEL     8'h02
`define DEF_WRITE_LEVEL    8'h03
`define DEF_OVERRUN        8'h04
`define DEF_TYPE           8'h05
`define DEF_MANDATORY      8'h06
`define READ_LEVEL         8'h00
`define WRITE_LEVEL        8'h0f
`define TYPE_U16           8'h04
`define TYPE_U32           8'h05
`define TYPE_STRUCT        8'h20
`define SIZE_U16           8'h02
`define SIZE_LIFE_STD      8'h08
`define SIZE_LIFE_SAFE     8'h0c
`define SIZE_LOG_ENTRY     8'h10
`define MANDATORY_NO       8'h00

// ==========================================================
// Lifetime offsets and fault log offsets
`define LIFE_OFF_OPER      16'h0000
`define LIFE_OFF_REVS      16'h0004
`define LIFE_OFF_REMAIN    16'h0008
`define LOG_HALF_FIRST     8'h00
`define LOG_HALF_SECOND    8'h01
`define LOG_DEPTH          16

// ==========================================================
// Fault codes (group 3 number 3, safety message 22)
`define FAULT_SPEED_RANGE  8'h33
`define FAULT_SAFETY_LIFE  8'h16

// ==========================================================
// Timing
`define CLK_PERIOD_NS      8
`define SECOND_NS          1000000000
`define SECOND_CYCLES      (`SECOND_NS / `CLK_PERIOD_NS)
`define SECONDS_PER_MINUTE 6'd60
`define SAVE_MINUTES       5'd20

`endif

/* design/monitor_res_pkg.sv */
/*
  Types of the monitoring resource server.
  Assumes the constants header sits beside it.
*/
package monitor_res_pkg;

  // Request sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } state_type;

  // One fault history entry, byte 15 at the top
  typedef logic [127:0] entry_type;

endpackage

/* design/encoder_monitor_resources.sv */
/*
  Monitoring resource server of a motor feedback encoder: answers
  parameter-channel requests for maximum speed, current speed,
  acceleration limit, lifetime counters and fault history, keeps the
  lifetime counters and the history. Assumes request fields are stable
  when the trigger pulses and an outside store saves nv_* on its strobe.
*/
`timescale 1ns/100ps
`include "monitor_res_regs.svh"

module encoder_monitor_resources #(
  parameter int          SECOND_CYCLES  = `SECOND_CYCLES,
  parameter bit          SAFETY_VARIANT = 1'b1,
  parameter logic [15:0] MAX_SPEED_RPM  = 16'h2ee0,
  parameter logic [15:0] ACCEL_LIMIT    = 16'h0064,
  parameter logic [31:0] TASK_LIFETIME  = 32'h0028_19a0,
  parameter logic [7:0]  TIME_OVERRUN   = 8'h0a,
  parameter logic [63:0] NAME_MAX_SPEED = "MAXSPEED",
  parameter logic [63:0] NAME_CUR_SPEED = "CURSPEED",
  parameter logic [63:0] NAME_ACCEL     = "ACCLIMIT",
  parameter logic [63:0] NAME_LIFE      = "LIFETIME",
  parameter logic [63:0] NAME_LOG       = "FAULTLOG"
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Parameter channel request
  input  wire logic [7:0]  param_resource_addr_high,
  input  wire logic [7:0]  param_resource_addr_low,
  input  wire logic [7:0]  param_offset_high,
  input  wire logic [7:0]  param_offset_low,
  input  wire logic        param_request_trigger,
  // Parameter channel answer
  output logic             request_complete_flag,
  output logic             request_refused,
  output logic [7:0]       param_data_byte_zero,
  output logic [7:0]       param_data_byte_one,
  output logic [7:0]       param_data_byte_two,
  output logic [7:0]       param_data_byte_three,
  output logic [7:0]       param_data_byte_four,
  output logic [7:0]       param_data_byte_five,
  output logic [7:0]       param_data_byte_six,
  output logic [7:0]       param_data_byte_seven,
  // Revolution ticks, and process values sampled into fault entries
  input  wire logic        rev_tick,
  input  wire logic [15:0] supply_mv,
  input  wire logic [15:0] tech_value,
  input  wire logic [15:0] temperature,
  // Fault sources
  input  wire logic        run_fault_valid,
  input  wire logic        link_fault_valid,
  input  wire logic [7:0]  fault_code_in,
  input  wire logic [7:0]  fault_extra_in,
  // Fault reports
  output logic             fault_valid,
  output logic [7:0]       fault_code,
  // Lifetime store
  output logic             nv_save_strobe,
  output logic [31:0]      nv_oper_minutes,
  output logic [31:0]      nv_revolutions,
  output logic [31:0]      nv_remaining
);

  // ==========================================================
  // Declarations
  monitor_res_pkg::state_type state_q;
  monitor_res_pkg::entry_type log_q [`LOG_DEPTH];
  monitor_res_pkg::entry_type new_entry;
  logic [15:0] addr_q;
  logic [15:0] offset_q;
  logic [63:0] buf_q;
  logic [63:0] resp_d;
  logic        refuse_d;
  logic        flag_q;
  logic        refused_q;
  logic [31:0] sec_cnt_q;
  logic        sec_tick;
  logic [5:0]  sec_of_min_q;
  logic        min_tick;
  logic [4:0]  min_of_save_q;
  logic [15:0] tick_cnt_q;
  logic [15:0] speed_q;
  logic [21:0] speed_calc;
  logic [15:0] speed_meas;
  logic        over_q;
  logic [31:0] oper_q;
  logic [31:0] revs_q;
  logic [31:0] remain_q;
  logic        fault_valid_q;
  logic [7:0]  fault_code_q;
  logic        save_q;
  logic [31:0] nv_oper_q;
  logic [31:0] nv_revs_q;
  logic [31:0] nv_remain_q;
  logic [3:0]  head_q;
  logic [4:0]  count_q;
  logic        log_we;
  logic [7:0]  log_code;
  logic        speed_over;
  logic        life_out;
  logic [3:0]  rd_idx;
  logic [9:0]  resource_identifier;

  assign resource_identifier = addr_q[9:0];

  // ==========================================================
  // Request sequencer: capture, then answer one cycle later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q  <= monitor_res_pkg::ST_IDLE;
      addr_q   <= 16'h0000;
      offset_q <= 16'h0000;
    end else begin
      unique case (state_q)
        monitor_res_pkg::ST_IDLE: begin
          if (param_request_trigger) begin
            addr_q   <= {param_resource_addr_high, param_resource_addr_low};
            offset_q <= {param_offset_high, param_offset_low};
            state_q  <= monitor_res_pkg::ST_BUSY;
          end
        end
        monitor_res_pkg::ST_BUSY: begin
          state_q <= monitor_res_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Completion flag and data buffer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_q    <= 1'b0;
      refused_q <= 1'b0;
      buf_q     <= 64'h0;
    end else if (param_request_trigger && state_q == monitor_res_pkg::ST_IDLE) begin
      flag_q <= 1'b0;
    end else if (state_q == monitor_res_pkg::ST_BUSY) begin
      flag_q    <= 1'b1;
      refused_q <= refuse_d;
      buf_q     <= resp_d;
    end
  end

  // ==========================================================
  // Answer builder
  function automatic logic [63:0] def_value(input logic [7:0] idx,
                                            input logic [63:0] name,
                                            input logic [7:0] size,
                                            input logic [7:0] dtype);
    logic [63:0] v;
    v = 64'h0;
    unique case (idx)
      `DEF_NAME:        v = name;
      `DEF_SIZE:        v[7:0] = size;
      `DEF_READ_LEVEL:  v[7:0] = `READ_LEVEL;
      `DEF_WRITE_LEVEL: v[7:0] = `WRITE_LEVEL;
      `DEF_OVERRUN:     v[7:0] = TIME_OVERRUN;
      `DEF_TYPE:        v[7:0] = dtype;
      default:          v[7:0] = `MANDATORY_NO;
    endcase
    return v;
  endfunction

  assign rd_idx = head_q - offset_q[3:0];

  always_comb begin
    resp_d   = 64'h0;
    refuse_d = 1'b0;
    if (!addr_q[`ADDR_DATA_BIT]) begin
      // Defining values of the selected resource
      unique case (resource_identifier)
        `RID_MAX_SPEED:   resp_d = def_value(offset_q[7:0], NAME_MAX_SPEED,
                                             `SIZE_U16, `TYPE_U16);
        `RID_CUR_SPEED:   resp_d = def_value(offset_q[7:0], NAME_CUR_SPEED,
                                             `SIZE_U16, `TYPE_U16);
        `RID_ACCEL_LIMIT: resp_d = def_value(offset_q[7:0], NAME_ACCEL,
                                             `SIZE_U16, `TYPE_U16);
        `RID_LIFETIME:    resp_d = def_value(offset_q[7:0], NAME_LIFE,
                                             SAFETY_VARIANT ? `SIZE_LIFE_SAFE
                                                            : `SIZE_LIFE_STD,
                                             `TYPE_U32);
        `RID_FAULT_LOG:   resp_d = def_value(offset_q[7:0], NAME_LOG,
                                             `SIZE_LOG_ENTRY, `TYPE_STRUCT);
        default:          refuse_d = 1'b1;
      endcase
      if (offset_q[15:8] != 8'h00 || offset_q[7:0] > `DEF_MANDATORY) begin
        refuse_d = 1'b1;
      end
    end else begin
      unique case (resource_identifier)
        `RID_MAX_SPEED: begin
          resp_d[15:0] = MAX_SPEED_RPM;
          refuse_d     = offset_q != 16'h0000;
        end
        `RID_CUR_SPEED: begin
          resp_d[15:0] = speed_q;
          refuse_d     = offset_q != 16'h0000;
        end
        `RID_ACCEL_LIMIT: begin
          resp_d[15:0] = ACCEL_LIMIT;
          refuse_d     = offset_q != 16'h0000;
        end
        `RID_LIFETIME: begin
          if (!addr_q[`ADDR_OFFSET_BIT] || offset_q == `LIFE_OFF_OPER) begin
            resp_d = {revs_q, oper_q};
          end else if (offset_q == `LIFE_OFF_REVS) begin
            resp_d[31:0] = revs_q;
          end else if (offset_q == `LIFE_OFF_REMAIN && SAFETY_VARIANT) begin
            resp_d[31:0] = remain_q;
          end else begin
            refuse_d = 1'b1;
          end
        end
        `RID_FAULT_LOG: begin
          if (offset_q == 16'h0000) begin
            resp_d[4:0] = count_q;
          end else if (offset_q[7:0] == 8'h00 || {3'b000, offset_q[7:0]} > {6'h00, count_q}
                       || offset_q[15:8] > `LOG_HALF_SECOND) begin
            refuse_d = 1'b1;
          end else if (offset_q[15:8] == `LOG_HALF_FIRST) begin
            resp_d = log_q[rd_idx][63:0];
          end else begin
            resp_d = log_q[rd_idx][127:64];
          end
        end
        default: refuse_d = 1'b1;
      endcase
      // Bytes beyond the requested length read as zero
      unique case (addr_q[`ADDR_LEN_HI:`ADDR_LEN_LO])
        2'b00:   resp_d = 64'h0;
        2'b01:   resp_d = {48'h0, resp_d[15:0]};
        2'b10:   resp_d = {32'h0, resp_d[31:0]};
        default: resp_d = resp_d;
      endcase
    end
  end

  // ==========================================================
  // One second and one minute timebase
  assign sec_tick = sec_cnt_q == 32'(SECOND_CYCLES - 1);
  assign min_tick = sec_tick && sec_of_min_q == `SECONDS_PER_MINUTE - 6'd1;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sec_cnt_q    <= 32'h0;
      sec_of_min_q <= 6'h00;
    end else begin
      sec_cnt_q <= sec_tick ? 32'h0 : sec_cnt_q + 32'h1;
      if (sec_tick) begin
        sec_of_min_q <= min_tick ? 6'h00 : sec_of_min_q + 6'h01;
      end
    end
  end

  // ==========================================================
  // Speed from revolutions counted over one second
  assign speed_calc = 22'(tick_cnt_q + {15'h0, rev_tick}) * 22'd60;
  assign speed_meas = (speed_calc > 22'h00ffff) ? 16'hffff : speed_calc[15:0];
  assign speed_over = sec_tick && speed_meas > MAX_SPEED_RPM;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt_q <= 16'h0;
      speed_q    <= 16'h0;
      over_q     <= 1'b0;
    end else if (sec_tick) begin
      tick_cnt_q <= 16'h0;
      speed_q    <= speed_meas;
      over_q     <= speed_over;
    end else if (rev_tick && tick_cnt_q != 16'hffff) begin
      tick_cnt_q <= tick_cnt_q + 16'h1;
    end
  end

  // ==========================================================
  // Lifetime counters
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oper_q   <= 32'h0;
      revs_q   <= 32'h0;
      remain_q <= TASK_LIFETIME;
    end else begin
      if (sec_tick) begin
        revs_q <= revs_q + {16'h0, tick_cnt_q} + {31'h0, rev_tick};
      end
      if (min_tick) begin
        oper_q <= oper_q + 32'h1;
        if (remain_q != 32'h0) begin
          remain_q <= remain_q - 32'h1;
        end
      end
    end
  end

  // Save snapshot every twenty minutes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      min_of_save_q <= 5'h00;
      save_q        <= 1'b0;
      nv_oper_q     <= 32'h0;
      nv_revs_q     <= 32'h0;
      nv_remain_q   <= 32'h0;
    end else begin
      save_q <= 1'b0;
      if (min_tick) begin
        if (min_of_save_q == `SAVE_MINUTES - 5'd1) begin
          min_of_save_q <= 5'h00;
          save_q        <= 1'b1;
          // Snapshot holds the values the counters take at this same edge
          nv_oper_q     <= oper_q + 32'h1;
          nv_revs_q     <= revs_q + {16'h0, tick_cnt_q} + {31'h0, rev_tick};
          nv_remain_q   <= remain_q - {31'h0, remain_q != 32'h0};
        end else begin
          min_of_save_q <= min_of_save_q + 5'h01;
        end
      end
    end
  end

  // ==========================================================
  // Fault reports: speed beyond limit, exhausted lifetime each second
  assign life_out = SAFETY_VARIANT && remain_q == 32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_valid_q <= 1'b0;
      fault_code_q  <= 8'h00;
    end else begin
      fault_valid_q <= 1'b0;
      if (sec_tick && life_out) begin
        fault_valid_q <= 1'b1;
        fault_code_q  <= `FAULT_SAFETY_LIFE;
      end else if (speed_over) begin
        fault_valid_q <= 1'b1;
        fault_code_q  <= `FAULT_SPEED_RANGE;
      end
    end
  end

  // ==========================================================
  // Fault history ring
  always_comb begin
    log_we   = 1'b1;
    log_code = fault_code_in;
    if (link_fault_valid || run_fault_valid) begin
      log_code = fault_code_in;
    end else if (speed_over && !over_q) begin
      log_code = `FAULT_SPEED_RANGE;
    end else begin
      log_we = 1'b0;
    end
  end

  assign new_entry = {log_code, fault_extra_in, 16'h0000, speed_q, supply_mv,
                      tech_value, temperature, oper_q};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      head_q  <= 4'h0;
      count_q <= 5'h00;
    end else if (log_we) begin
      head_q <= head_q + 4'h1;
      if (count_q != 5'(`LOG_DEPTH)) begin
        count_q <= count_q + 5'h01;
      end
    end
  end

  // Entry storage, oldest slot reused when full
  for (genvar i = 0; i < `LOG_DEPTH; i++) begin : g_log
    always_ff @(posedge clk) begin
      if (log_we && head_q == 4'(i)) begin
        log_q[i] <= new_entry;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign request_complete_flag = flag_q;
  assign request_refused       = refused_q;
  assign param_data_byte_zero  = buf_q[7:0];
  assign param_data_byte_one   = buf_q[15:8];
  assign param_data_byte_two   = buf_q[23:16];
  assign param_data_byte_three = buf_q[31:24];
  assign param_data_byte_four  = buf_q[39:32];
  assign param_data_byte_five  = buf_q[47:40];
  assign param_data_byte_six   = buf_q[55:48];
  assign param_data_byte_seven = buf_q[63:56];
  assign fault_valid           = fault_valid_q;
  assign fault_code            = fault_code_q;
  assign nv_save_strobe        = save_q;
  assign nv_oper_minutes       = nv_oper_q;
  assign nv_revolutions        = nv_revs_q;
  assign nv_remaining          = nv_remain_q;

  // ==========================================================
  // Checks
  sequence s_answer;
    !request_complete_flag ##1 request_complete_flag;
  endsequence

  a_flag_after_req: assert property (@(posedge clk) disable iff (sys_rst)
    param_request_trigger && state_q == monitor_res_pkg::ST_IDLE |=> s_answer)
    else $error("completion flag not raised two edges after trigger");
  a_speed_fault: assert property (@(posedge clk) disable iff (sys_rst)
    speed_over && !life_out |=> fault_valid && fault_code == 8'h33)
    else $error("speed fault not reported");
  a_safety_repeat: assert property (@(posedge clk) disable iff (sys_rst)
    sec_tick && life_out |=> fault_valid && fault_code == 8'h16)
    else $error("lifetime safety fault not repeated");
  a_oper_minute: assert property (@(posedge clk) disable iff (sys_rst)
    min_tick |=> oper_q == $past(oper_q) + 32'h1)
    else $error("operating minutes not advanced");
  a_save_interval: assert property (@(posedge clk) disable iff (sys_rst)
    nv_save_strobe |-> $past(min_tick) && $past(min_of_save_q) == 5'd19)
    else $error("save outside twenty minute point");
  a_log_count: assert property (@(posedge clk) disable iff (sys_rst)
    log_we && count_q < 5'd16 |=> count_q == $past(count_q) + 5'd1)
    else $error("stored count not advanced");
  a_log_full: assert property (@(posedge clk) disable iff (sys_rst)
    count_q == 5'd16 |=> count_q == 5'd16)
    else $error("full history count changed");
  a_speed_read: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == monitor_res_pkg::ST_BUSY && addr_q == 16'h54c6 && offset_q == 16'h0
      |=> buf_q[15:0] == MAX_SPEED_RPM && !request_refused)
    else $error("maximum speed read wrong");

endmodule // encoder_monitor_resources

/* verification/param_master.sv */
/*
  Drive-side master model of the parameter channel: places one request,
  waits for the completion flag and keeps the answer.
  Assumes the block answers one edge after the edge that takes the trigger.
*/
`timescale 1ns/100ps
module param_master (
  // Clock
  input  wire logic        clk,
  // Request
  output logic [7:0]       addr_high,
  output logic [7:0]       addr_low,
  output logic [7:0]       off_high,
  output logic [7:0]       off_low,
  output logic             trigger,
  // Answer
  input  wire logic        flag,
  input  wire logic        refused,
  input  wire logic [63:0] answer,
  output logic [63:0]      rdata,
  output logic             rrefused,
  output logic             timed_out
);
  // ==========================================================
  // One long-message request, whole value at the given offset
  initial begin
    {addr_high, addr_low, off_high, off_low, trigger} = '0;
  end
  task automatic read_res(input logic [7:0] ah, al, oh, ol);
    int n;
    n = 0;
    @(posedge clk);
    addr_high <= ah;
    addr_low  <= al;
    off_high  <= oh;
    off_low   <= ol;
    trigger   <= 1'b1;
    @(posedge clk);
    trigger <= 1'b0;
    @(posedge clk);
    #1;
    // Bounded wait for the completion flag
    while (flag !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    timed_out = (flag !== 1'b1);
    rdata     = answer;
    rrefused  = refused;
  endtask
endmodule // param_master

/* verification/encoder_monitor_resources_test.sv */
/*
  Self-checking bench of the monitoring resource server.
  Assumes a short second of 20 cycles and a master model beside it.
*/
`timescale 1ns/100ps
module encoder_monitor_resources_test;
  localparam int SEC = 20;
  logic        clk = 1'b0, sys_rst = 1'b1, rev_tick = 1'b0, rev_en = 1'b0;
  logic        run_fault_valid = 1'b0, link_fault_valid = 1'b0;
  logic [7:0]  fault_code_in = 8'h00, fault_extra_in = 8'h5a;
  logic [15:0] supply_mv = 16'h5dc0, tech_value = 16'h1234, temperature = 16'hff9c;
  logic [7:0]  ah, al, oh, ol, b0, b1, b2, b3, b4, b5, b6, b7, fault_code;
  logic        trig, flag, refd, fault_valid, nv_save_strobe;
  logic [31:0] nv_oper_minutes, nv_revolutions, nv_remaining;
  int          mismatches = 0, compares = 0, cyc = 0, n_speed = 0, n_life = 0, n_rev = 0;

  // ==========================================================
  // Block, master model and clock
  encoder_monitor_resources #(.SECOND_CYCLES(SEC), .MAX_SPEED_RPM(16'd100),
    .TASK_LIFETIME(32'd22)) uut (.clk(clk), .sys_rst(sys_rst),
    .param_resource_addr_high(ah), .param_resource_addr_low(al),
    .param_offset_high(oh), .param_offset_low(ol), .param_request_trigger(trig),
    .request_complete_flag(flag), .request_refused(refd),
    .param_data_byte_zero(b0), .param_data_byte_one(b1), .param_data_byte_two(b2),
    .param_data_byte_three(b3), .param_data_byte_four(b4), .param_data_byte_five(b5),
    .param_data_byte_six(b6), .param_data_byte_seven(b7), .rev_tick(rev_tick),
    .supply_mv(supply_mv), .tech_value(tech_value), .temperature(temperature),
    .run_fault_valid(run_fault_valid), .link_fault_valid(link_fault_valid),
    .fault_code_in(fault_code_in), .fault_extra_in(fault_extra_in),
    .fault_valid(fault_valid), .fault_code(fault_code), .nv_save_strobe(nv_save_strobe),
    .nv_oper_minutes(nv_oper_minutes), .nv_revolutions(nv_revolutions),
    .nv_remaining(nv_remaining));
  param_master master (.clk(clk), .addr_high(ah), .addr_low(al), .off_high(oh),
    .off_low(ol), .trigger(trig), .flag(flag), .refused(refd),
    .answer({b7, b6, b5, b4, b3, b2, b1, b0}), .rdata(), .rrefused(), .timed_out());
  always #4 clk = ~clk;

  // Revolution ticks every 10 cycles, fault counting and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rev_tick <= rev_en && (cyc % 10 == 0);
    if (rev_tick === 1'b1) n_rev++;
    if (fault_valid === 1'b1 && fault_code === 8'h33) n_speed++;
    if (fault_valid === 1'b1 && fault_code === 8'h16) n_life++;
    if (cyc == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [63:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_n(input int got, exp, input string what);
    compares++;
    if (got != exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] h, l, oh_v, ol_v);
    master.read_res(h, l, oh_v, ol_v);
    chk({63'h0, master.timed_out}, 64'h0, "answer wait");
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_defining();
    logic [7:0] exp [4] = '{8'h02, 8'h00, 8'h0f, 8'h04};
    for (int i = 0; i < 4; i++) begin
      rd(8'h4c, 8'hc6, 8'h00, 8'h01 + (i == 3 ? 8'h04 : i[7:0]));
      chk({56'h0, master.rdata[7:0]}, {56'h0, exp[i]}, "speed def");
    end
    rd(8'h4c, 8'hc6, 8'h00, 8'h00);
    chk(master.rdata, "MAXSPEED", "speed name");
    rd(8'h4c, 8'hc6, 8'h00, 8'h07);
    chk({63'h0, master.rrefused}, 64'h1, "def index 7");
    rd(8'h4c, 8'hcb, 8'h00, 8'h01);
    chk({56'h0, master.rdata[7:0]}, 64'h0c, "life size");
    rd(8'h4c, 8'hcb, 8'h00, 8'h05);
    chk({56'h0, master.rdata[7:0]}, 64'h05, "life type");
    rd(8'h4c, 8'hcc, 8'h00, 8'h05);
    chk({56'h0, master.rdata[7:0]}, 64'h20, "log type");
    rd(8'h54, 8'hc6, 8'h00, 8'h00);
    chk({48'h0, master.rdata[15:0]}, 64'd100, "max speed");
    rd(8'h54, 8'hc8, 8'h00, 8'h00);
    chk({48'h0, master.rdata[15:0]}, 64'h0064, "accel limit");
    rd(8'h54, 8'hc8, 8'h00, 8'h02);
    chk({63'h0, master.rrefused}, 64'h1, "accel offset 2");
    $display("test defining values done");
  endtask

  task automatic t_speed();
    rev_en <= 1'b1;
    repeat (3 * SEC) @(posedge clk);
    #1;
    n_speed = 0;
    repeat (2 * SEC) @(posedge clk);
    #1;
    chk_n(n_speed, 2, "speed faults");
    rd(8'h54, 8'hc7, 8'h00, 8'h00);
    chk({48'h0, master.rdata[15:0]}, 64'd120, "current speed");
    rev_en <= 1'b0;
    rd(8'h7c, 8'hcc, 8'h00, 8'h00);
    chk({56'h0, master.rdata[7:0]}, 64'd1, "log count");
    rd(8'h7c, 8'hcc, 8'h00, 8'h01);
    chk(master.rdata, {tech_value, temperature, 32'h0}, "entry first half");
    repeat (3 * SEC) @(posedge clk);
    $display("test speed done");
  endtask

  task automatic t_log();
    for (int i = 1; i <= 17; i++) begin
      @(posedge clk);
      run_fault_valid <= 1'b1;
      fault_code_in   <= i[7:0];
    end
    @(posedge clk);
    run_fault_valid  <= 1'b0;
    link_fault_valid <= 1'b1;
    fault_code_in    <= 8'ha0;
    @(posedge clk);
    link_fault_valid <= 1'b0;
    rd(8'h7c, 8'hcc, 8'h00, 8'h00);
    chk({56'h0, master.rdata[7:0]}, 64'd16, "full count");
    rd(8'h7c, 8'hcc, 8'h00, 8'h01);
    chk(master.rdata, {tech_value, temperature, 32'h0}, "newest first half");
    rd(8'h7c, 8'hcc, 8'h01, 8'h01);
    chk(master.rdata, {16'ha05a, 32'h0, supply_mv}, "newest entry");
    rd(8'h7c, 8'hcc, 8'h01, 8'h02);
    chk({56'h0, master.rdata[63:56]}, 64'h11, "entry 2");
    rd(8'h7c, 8'hcc, 8'h01, 8'h10);
    chk({56'h0, master.rdata[63:56]}, 64'h03, "oldest entry");
    rd(8'h7c, 8'hcc, 8'h00, 8'h11);
    chk({63'h0, master.rrefused}, 64'h1, "entry 17");
    $display("test fault history done");
  endtask

  task automatic t_life();
    int n;
    n = 0;
    while (nv_save_strobe !== 1'b1 && n < 30000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({32'h0, nv_oper_minutes}, 64'd20, "saved minutes");
    chk({32'h0, nv_remaining}, 64'd2, "saved remaining");
    chk({32'h0, nv_revolutions}, 64'(n_rev), "saved revolutions");
    rd(8'h78, 8'hcb, 8'h00, 8'h04);
    chk({32'h0, master.rdata[31:0]}, 64'(n_rev), "revolutions");
    rd(8'h78, 8'hcb, 8'h00, 8'h00);
    chk({32'h0, master.rdata[31:0]}, 64'd20, "oper time");
    rd(8'h78, 8'hcb, 8'h00, 8'h08);
    chk({32'h0, master.rdata[31:0]}, 64'd2, "remaining");
    repeat (2 * 60 * SEC + 40) @(posedge clk);
    #1;
    n_life = 0;
    repeat (5 * SEC) @(posedge clk);
    #1;
    chk_n(n_life, 5, "lifetime faults");
    $display("test lifetime done");
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({62'h0, flag, fault_valid}, 64'h0, "after reset");
    t_defining();
    t_speed();
    t_log();
    t_life();
    report_and_stop();
  end
endmodule // encoder_monitor_resources_test
